// [adcts_pkg.sv]
// Shared constants and types of the converter trigger sequencer
`default_nettype none
package adcts_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets on the APB slave
  localparam logic [7:0] ADDR_TRIG_CTRL = 8'h00; // adc_trigger_control
  localparam logic [7:0] ADDR_CONV_CTRL = 8'h04; // Start, mode and channel setup
  localparam logic [7:0] ADDR_STATUS = 8'h08; // Live sequencer state
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h0c; // Sticky events, read only
  localparam logic [7:0] ADDR_IRQ_CLR = 8'h10; // Write one to clear, write only
  localparam logic [7:0] ADDR_IRQ_EN = 8'h14; // Event enables
  localparam logic [7:0] ADDR_RESULT0 = 8'h20; // First of four result words

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int TRIG_EN_LSB = 0; // trigger_source_enables [4:0]
  localparam int TRIG_RSVD_BIT = 5; // Unimplemented, reads zero
  localparam int DEPTH_LSB = 6; // buffer_depth_irq_select [7:6]
  localparam int CC_GO_BIT = 0; // Start/done
  localparam int CC_MULTI_BIT = 1; // multi_channel_enable
  localparam int CC_MODE_LSB = 2; // sequence_mode_select [3:2]
  localparam int CC_LOOP_BIT = 4; // Continuous loop when set
  localparam int CC_GSEL_LSB = 8; // group_channel_select, 2 bits per group A..D
  localparam int CC_ACQ_LSB = 16; // acquisition_time in converter clocks [23:16]
  localparam int ST_EMPTY_BIT = 0; // result_buffer_empty
  localparam int ST_BUSY_BIT = 1; // Sequence running
  localparam int ST_WPTR_LSB = 2; // Next result slot [3:2]
  localparam int EV_CONV_IRQ = 0; // converter_irq_flag
  localparam int EV_HW_TRIG = 1; // Hardware trigger accepted
  localparam int EV_DROPPED = 2; // Start request dropped while busy

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and field codes
  localparam logic [7:0] TRIG_CTRL_RST = 8'h00;
  localparam logic [7:0] TRIG_WR_MASK = 8'hdf;
  localparam logic [2:0] IRQ_EN_RST = 3'h0;
  localparam logic [1:0] DEPTH_EACH = 2'h0;
  localparam logic [1:0] DEPTH_TWO_FOUR = 2'h1;
  localparam logic [1:0] DEPTH_FOUR = 2'h2;
  localparam logic [1:0] MODE_SEQ2 = 2'h0; // sequential_two_group
  localparam logic [1:0] MODE_SEQ4 = 2'h1; // sequential_four_group
  localparam logic [1:0] MODE_SIM2 = 2'h2; // simultaneous_two_group
  localparam logic [1:0] MODE_SIM4 = 2'h3; // simultaneous_four_group

  ////////////////////////////////////////////////////////////////////////////
  // Timing: converter clock period and the acquisition used when zero is programmed
  localparam int MCLK_NS = 8;
  localparam int TAD_NS = 400;
  localparam int TAD_CYC = (TAD_NS + MCLK_NS - 1) / MCLK_NS;
  localparam logic [7:0] ACQ_MIN_TAD = 8'h02;

  ////////////////////////////////////////////////////////////////////////////
  // Request to the sample-and-hold circuits and the converter core
  typedef struct packed {
    logic [1:0] sample; // Bit 0 holds group A/C or the single group, bit 1 group B/D
    logic start; // One-cycle conversion start
    logic [1:0] group; // Group to convert
    logic [1:0] chan; // Channel within the group
  } adcts_conv_req_t;

endpackage
`default_nettype wire

// [adcts_top.sv]
// Converter trigger selector, start/done control and conversion sequencer
//
// Added by the designer: the APB register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module adcts_top (
  input wire logic mclk, // System clock, 125 MHz
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction, high for write
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic [4:0] trig_in, // Pin, overflow, capture, compare, PWM
  output adcts_pkg::adcts_conv_req_t conv_req, // To sample-and-hold and core
  input wire logic conv_done, // Core finished, one-cycle pulse
  input wire logic [9:0] conv_result, // Core result, valid with conv_done
  output logic irq // Level interrupt
);
  import adcts_pkg::*;

  typedef enum logic [1:0] {S_IDLE, S_ACQ, S_START, S_WAIT} adcts_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Reset release
  logic [1:0] rst_pipe_r; // Release synchroniser
  logic rst_s_n; // Synchronised reset used everywhere

  // Assert at once, release after two edges
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_pipe_r <= 2'h0;
    end else begin
      rst_pipe_r <= {rst_pipe_r[0], 1'b1};
    end
  end
  assign rst_s_n = rst_pipe_r[1];

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [7:0] trig_ctrl_r; // adc_trigger_control
  logic go_r; // Start/done bit
  logic multi_r; // multi_channel_enable
  logic [1:0] mode_r; // sequence_mode_select
  logic loop_r; // Continuous loop
  logic [7:0] gsel_r; // group_channel_select, A in low bits
  logic [7:0] acq_r; // acquisition_time
  logic [2:0] stat_r; // Sticky events
  logic [2:0] irq_en_r; // Event enables
  logic irq_r; // Interrupt flop
  logic pready_r; // APB ready flop
  logic pslverr_r; // APB error flop
  logic [31:0] prdata_r; // APB read data flop
  logic [4:0] trig_s1_r; // First synchroniser stage
  logic [4:0] trig_s2_r; // Second synchroniser stage
  logic [4:0] trig_d_r; // Previous synchronised level
  logic [4:0] trig_rise; // One-cycle rising edges
  logic hw_fire; // Enabled hardware event
  adcts_state_t state_r; // Sequencer state
  logic [1:0] step_r; // Group index in the sequence
  logic [5:0] tad_cnt_r; // Converter clock divider
  logic tad_tick; // Converter clock enable
  logic [7:0] acq_cnt_r; // Acquisition progress in converter clocks
  logic [7:0] acq_len; // Acquisition length in converter clocks
  logic [9:0] res_mem_r [4]; // Result buffer
  logic [1:0] wptr_r; // Next result slot
  logic empty_r; // result_buffer_empty
  adcts_conv_req_t req_r; // Converter request flops
  logic wr_fire; // APB write completes this edge
  logic rd_take; // APB read data captured this edge
  logic sw_go; // Software start write
  logic start_req; // New sequence begins
  logic sim; // Simultaneous sampling selected
  logic [1:0] last_step; // Final group index
  logic [1:0] cur_group; // Group being handled
  logic wr_res; // Result written this edge
  logic seq_end; // Last conversion done
  logic depth_hit; // Loop-mode interrupt point
  logic irq_evt; // converter_irq_flag event
  logic [2:0] stat_set; // Events this cycle
  logic [31:0] rd_data; // Read mux
  logic rd_ok; // Address is mapped

  ////////////////////////////////////////////////////////////////////////////
  // Trigger capture: two flops, then edge detect on the clean copy
  always_ff @(posedge mclk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      trig_s1_r <= 5'h00;
      trig_s2_r <= 5'h00;
      trig_d_r <= 5'h00;
    end else begin
      trig_s1_r <= trig_in;
      trig_s2_r <= trig_s1_r;
      trig_d_r <= trig_s2_r;
    end
  end

  // Per-source edge and enable gate
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_trig
      assign trig_rise[gi] = trig_s2_r[gi] & ~trig_d_r[gi] & trig_ctrl_r[TRIG_EN_LSB + gi];
    end
  endgenerate
  // Any enabled edge starts when idle; zero enables never fire
  assign hw_fire = |trig_rise;

  ////////////////////////////////////////////////////////////////////////////
  // APB handshake: ready comes one cycle into the access phase
  assign rd_take = psel & penable & ~pready_r & ~pwrite;
  assign wr_fire = psel & penable & pready_r & pwrite;
  assign sw_go = wr_fire & (paddr == ADDR_CONV_CTRL) & pwdata[CC_GO_BIT];

  // Ready, error and read data
  always_ff @(posedge mclk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0;
    end else begin
      pready_r <= psel & penable & ~pready_r;
      if (psel & penable & ~pready_r) begin
        pslverr_r <= ~rd_ok;
      end
      if (rd_take) begin
        prdata_r <= rd_data;
      end
    end
  end

  // Read mux; write-only clear register reads zero
  always_comb begin
    rd_data = 32'h0;
    rd_ok = 1'b1;
    unique case (paddr)
      ADDR_TRIG_CTRL: rd_data[7:0] = trig_ctrl_r & TRIG_WR_MASK;
      ADDR_CONV_CTRL: rd_data = {8'h00, acq_r, gsel_r, 3'h0, loop_r, mode_r, multi_r, go_r};
      ADDR_STATUS: rd_data[3:0] = {wptr_r, state_r != S_IDLE, empty_r};
      ADDR_IRQ_STAT: rd_data[2:0] = stat_r;
      ADDR_IRQ_CLR: rd_data = 32'h0;
      ADDR_IRQ_EN: rd_data[2:0] = irq_en_r;
      ADDR_RESULT0: rd_data[9:0] = res_mem_r[0];
      ADDR_RESULT0 + 8'h04: rd_data[9:0] = res_mem_r[1];
      ADDR_RESULT0 + 8'h08: rd_data[9:0] = res_mem_r[2];
      ADDR_RESULT0 + 8'h0c: rd_data[9:0] = res_mem_r[3];
      default: rd_ok = 1'b0; // Unmapped: error, zero data
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software setup registers
  always_ff @(posedge mclk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      trig_ctrl_r <= TRIG_CTRL_RST;
      multi_r <= 1'b0;
      mode_r <= 2'h0;
      loop_r <= 1'b0;
      gsel_r <= 8'h00;
      acq_r <= 8'h00;
      irq_en_r <= IRQ_EN_RST;
    end else if (wr_fire) begin
      if (paddr == ADDR_TRIG_CTRL) begin
        trig_ctrl_r <= pwdata[7:0] & TRIG_WR_MASK;
      end
      // Mode changes mid-sequence would corrupt step order, so they are ignored while busy
      if (paddr == ADDR_CONV_CTRL && state_r == S_IDLE) begin
        multi_r <= pwdata[CC_MULTI_BIT];
        mode_r <= pwdata[CC_MODE_LSB +: 2];
        gsel_r <= pwdata[CC_GSEL_LSB +: 8];
        acq_r <= pwdata[CC_ACQ_LSB +: 8];
      end
      // Loop bit may drop at any time to end a running loop
      if (paddr == ADDR_CONV_CTRL) begin
        loop_r <= pwdata[CC_LOOP_BIT];
      end
      if (paddr == ADDR_IRQ_EN) begin
        irq_en_r <= pwdata[2:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequence shape
  assign sim = multi_r & mode_r[1];
  // Last group: single 0, two-group 1, four-group 3
  assign last_step = !multi_r ? 2'h0 : (mode_r[0] ? 2'h3 : 2'h1);
  assign cur_group = multi_r ? step_r : mode_r;
  assign start_req = state_r == S_IDLE && (sw_go || hw_fire);
  assign wr_res = state_r == S_WAIT && conv_done;
  assign seq_end = wr_res && step_r == last_step;
  assign acq_len = (acq_r == 8'h00) ? ACQ_MIN_TAD : acq_r;

  // Converter clock enable, free running
  assign tad_tick = tad_cnt_r == 6'(TAD_CYC - 1);
  always_ff @(posedge mclk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      tad_cnt_r <= 6'h00;
    end else begin
      tad_cnt_r <= tad_tick ? 6'h00 : tad_cnt_r + 6'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: acquire, start, wait for the core
  always_ff @(posedge mclk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      state_r <= S_IDLE;
      step_r <= 2'h0;
      acq_cnt_r <= 8'h00;
    end else begin
      unique case (state_r)
        S_IDLE: begin
          if (start_req) begin
            state_r <= S_ACQ;
            step_r <= 2'h0;
            acq_cnt_r <= 8'h00;
          end
        end
        S_ACQ: begin
          // Sample for the programmed number of converter clocks, two when it is zero
          if (tad_tick) begin
            acq_cnt_r <= acq_cnt_r + 8'h01;
            if (acq_cnt_r + 8'h01 >= acq_len) begin
              state_r <= S_START;
            end
          end
        end
        S_START: state_r <= S_WAIT;
        S_WAIT: begin
          if (seq_end) begin
            // Loop restarts at step 0 (group A when multi-group); single-shot goes idle
            state_r <= loop_r ? S_ACQ : S_IDLE;
            step_r <= 2'h0;
            acq_cnt_r <= 8'h00;
          end else if (wr_res) begin
            step_r <= step_r + 2'h1;
            acq_cnt_r <= 8'h00;
            // Second of a simultaneous pair is already held
            state_r <= (sim && !step_r[0]) ? S_START : S_ACQ;
          end
        end
      endcase
    end
  end

  // Start/done: set by any start, cleared when a non-looping sequence ends
  always_ff @(posedge mclk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      go_r <= 1'b0;
    end else if (start_req) begin
      go_r <= 1'b1;
    end else if (seq_end && !loop_r) begin
      go_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Requests to sample-and-hold and core
  always_ff @(posedge mclk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      req_r <= '0;
    end else begin
      req_r.start <= state_r == S_START;
      req_r.group <= cur_group;
      req_r.chan <= gsel_r[{cur_group, 1'b0} +: 2];
      if (state_r != S_ACQ) begin
        req_r.sample <= 2'h0;
      end else if (sim) begin
        req_r.sample <= 2'h3;
      end else begin
        req_r.sample <= step_r[0] ? 2'h2 : 2'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result buffer and empty flag
  always_ff @(posedge mclk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      wptr_r <= 2'h0;
      empty_r <= 1'b1;
    end else if (start_req) begin
      wptr_r <= 2'h0;
      empty_r <= 1'b1;
    end else if (wr_res) begin
      wptr_r <= wptr_r + 2'h1;
      empty_r <= 1'b0;
    end
  end

  // Result storage; no reset needed on data
  always_ff @(posedge mclk) begin
    if (wr_res) begin
      res_mem_r[wptr_r] <= conv_result;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt point: depth field only counts in loop mode
  always_comb begin
    unique case (trig_ctrl_r[DEPTH_LSB +: 2])
      DEPTH_EACH: depth_hit = 1'b1;
      DEPTH_TWO_FOUR: depth_hit = wptr_r[0];
      DEPTH_FOUR: depth_hit = wptr_r == 2'h3;
      default: depth_hit = 1'b0; // Unimplemented code never fires
    endcase
  end
  // Single-shot flags at sequence end, whatever the depth field says
  assign irq_evt = loop_r ? (wr_res && depth_hit) : seq_end;
  assign stat_set = {(sw_go || hw_fire) && state_r != S_IDLE, hw_fire && state_r == S_IDLE, irq_evt};

  // Sticky events: set beats a clear in the same cycle
  always_ff @(posedge mclk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      stat_r <= 3'h0;
      irq_r <= 1'b0;
    end else begin
      if (wr_fire && paddr == ADDR_IRQ_CLR) begin
        stat_r <= (stat_r & ~pwdata[2:0]) | stat_set;
      end else begin
        stat_r <= stat_r | stat_set;
      end
      irq_r <= |(stat_r & irq_en_r);
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign conv_req = req_r;
  assign irq = irq_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_s_n);

  sequence seq_idle_start;
    state_r == S_IDLE ##0 (sw_go || hw_fire);
  endsequence
  sequence seq_running;
    state_r == S_ACQ ##1 state_r == S_START ##1 state_r == S_WAIT;
  endsequence

  a_rsvd_zero: assert property (rd_take && paddr == ADDR_TRIG_CTRL |=> !prdata[TRIG_RSVD_BIT])
    else $error("Reserved trigger bit read nonzero");
  a_no_trigger: assert property (state_r == S_IDLE && trig_ctrl_r[4:0] == 5'h00 && !sw_go |=> state_r == S_IDLE)
    else $error("Sequence began with no start source");
  a_start_sets: assert property (seq_idle_start |=> go_r && state_r == S_ACQ)
    else $error("Start did not set start/done");
  a_sw_any_sel: assert property (state_r == S_IDLE && sw_go |=> go_r)
    else $error("Software start was lost");
  a_busy_ignore: assert property (state_r != S_IDLE && !seq_end |=> go_r && state_r != S_IDLE)
    else $error("Busy sequence disturbed");
  a_done_clear: assert property (seq_end && !loop_r |=> !go_r && state_r == S_IDLE && stat_r[EV_CONV_IRQ])
    else $error("Single-shot end not reported");
  a_depth_four: assert property (wr_res && loop_r && trig_ctrl_r[7:6] == DEPTH_FOUR && wptr_r != 2'h3
      && !stat_r[EV_CONV_IRQ] |=> !stat_r[EV_CONV_IRQ])
    else $error("Depth-four interrupt fired early");
  a_empty_clear: assert property (wr_res |=> !empty_r)
    else $error("Empty flag stayed set");
  a_sim_pair: assert property (sim && wr_res && !step_r[0] && !seq_end |=> state_r == S_START ##1
      conv_req.sample == 2'h0 && conv_req.start)
    else $error("Held partner was resampled");
  a_acq_order: assert property (seq_running |-> conv_req.start)
    else $error("Conversion did not follow acquisition");
  // Pin must have risen exactly two flops earlier on an enabled source
  a_sync_edge: assert property (hw_fire |-> |(trig_ctrl_r[4:0] & $past(trig_in, 2) & ~$past(trig_in, 3)))
    else $error("Trigger fired without a synchronised pin edge");

endmodule // adcts_top
`default_nettype wire

// [adcts_core_model.sv]
// Behavioural converter core that answers the sequencer's start pulses
`timescale 1ns/100ps
`default_nettype none
module adcts_core_model (
  input wire logic mclk, // System clock
  input wire logic rst_n, // Active low reset
  input wire adcts_pkg::adcts_conv_req_t req, // Request from the sequencer
  input wire logic slow, // Long conversion when set
  output logic done, // One-cycle finish pulse
  output logic [9:0] result // Result, valid with done only
);
  import adcts_pkg::*;
  logic [5:0] cnt_r; // Cycles left in the conversion
  logic [3:0] tag_r; // Group and channel in flight
  ////////////////////////////////////////
  // Count down; the result never lingers, so a late read shows garbage
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 6'h00;
      tag_r <= 4'h0;
      done <= 1'b0;
      result <= 10'h000;
    end else begin
      done <= (cnt_r == 6'h01);
      result <= (cnt_r == 6'h01) ? {6'h15, tag_r} : ~result;
      if (req.start) begin // New conversion
        cnt_r <= slow ? 6'h28 : 6'h06;
        tag_r <= {req.group, req.chan};
      end else if (cnt_r != 6'h00) begin // Busy converting
        cnt_r <= cnt_r - 6'h01;
      end
    end
  end
endmodule // adcts_core_model
`default_nettype wire

// [adc_trigger_sequencer_bench.sv]
// Self-checking bench of the converter trigger sequencer
`timescale 1ns/100ps
`default_nettype none
module adc_trigger_sequencer_bench;
  import adcts_pkg::*;
  typedef struct packed {logic [31:0] cc; logic [2:0] n; logic sim; logic slow;} adcts_row_t;
  logic mclk, rst_n, psel, penable, pwrite, pready, pslverr, conv_done, irq, slow, rd_e, both_seen, samp_hi;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd_v;
  logic [4:0] trig_in, en, fire;
  logic [9:0] conv_result;
  logic [1:0] g;
  adcts_conv_req_t conv_req;
  int error_cnt, samples_checked, done_cnt, samp_len, last_len, base, na;
  // Mode rows: control word, conversions, both-held, slow core
  adcts_row_t rows [8] = '{'{32'he401, 3'd1, 1'b0, 1'b0}, '{32'he405, 3'd1, 1'b0, 1'b1},
    '{32'he409, 3'd1, 1'b0, 1'b0}, '{32'he40d, 3'd1, 1'b0, 1'b1}, '{32'h1b03, 3'd2, 1'b0, 1'b0},
    '{32'h1b07, 3'd4, 1'b0, 1'b1}, '{32'h1b0b, 3'd2, 1'b1, 1'b0}, '{32'h1b0f, 3'd4, 1'b1, 1'b1}};
  adcts_top DUT (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .trig_in(trig_in), .conv_req(conv_req), .conv_done(conv_done), .conv_result(conv_result), .irq(irq));
  adcts_core_model core (.mclk(mclk), .rst_n(rst_n), .req(conv_req), .slow(slow), .done(conv_done),
    .result(conv_result));
  ////////////////////////////////////////
  // Clock and a monitor of the converter side
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (conv_done === 1'b1) done_cnt++;
    if (conv_req.sample === 2'b11) both_seen = 1'b1;
    if (conv_req.start === 1'b1) last_len = samp_len;
    if (conv_req.sample != 2'b00) samp_len = samp_hi ? samp_len + 1 : 1;
    samp_hi = (conv_req.sample != 2'b00);
  end
  ////////////////////////////////////////
  // Shared tasks
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One APB transfer; held until pready, released after
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd_v = prdata;
    rd_e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Poll busy, bounded so a stuck sequencer still ends
  task automatic wait_idle();
    for (int t = 0; t < 500; t++) begin
      apb(1'b0, ADDR_STATUS, 32'h0);
      if (rd_v[ST_BUSY_BIT] === 1'b0) break;
    end
  endtask
  // Three-cycle trigger pulse, wide enough for the synchroniser
  task automatic pulse(input logic [4:0] v);
    @(posedge mclk);
    trig_in <= v;
    repeat (3) @(posedge mclk);
    trig_in <= 5'h00;
    repeat (8) @(posedge mclk);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Watchdog: tests need about 6000 cycles
  initial begin
    repeat (60000) @(posedge mclk);
    error_cnt++;
    wrap_up();
  end
  ////////////////////////////////////////
  // Main sequence
  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata, trig_in, slow} = '0;
    {error_cnt, samples_checked, done_cnt, samp_len, last_len} = '0;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    apb(1'b0, ADDR_TRIG_CTRL, 32'h0);
    chk("trig_ctrl", rd_v, 32'h0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("status", rd_v, 32'h1);
    apb(1'b1, ADDR_TRIG_CTRL, 32'hff);
    apb(1'b0, ADDR_TRIG_CTRL, 32'h0);
    chk("trig_ctrl_rsvd", rd_v, 32'hdf);
    apb(1'b0, 8'h40, 32'h0);
    chk("slverr", {31'h0, rd_e}, 32'h1);
    $display("test reset done");
    // Depth code for four words must not matter in single-shot
    apb(1'b1, ADDR_TRIG_CTRL, 32'h80);
    foreach (rows[i]) begin
      slow <= rows[i].slow;
      apb(1'b1, ADDR_IRQ_CLR, 32'h7);
      both_seen = 1'b0;
      base = done_cnt;
      apb(1'b1, ADDR_CONV_CTRL, rows[i].cc);
      wait_idle();
      chk("conversions", done_cnt - base, {29'h0, rows[i].n});
      for (int k = 0; k < rows[i].n; k++) begin
        g = rows[i].cc[1] ? k[1:0] : rows[i].cc[3:2];
        apb(1'b0, ADDR_RESULT0 + 8'(4 * k), 32'h0);
        chk("result", rd_v, {22'h0, 6'h15, g, rows[i].cc[8 + 2 * g +: 2]});
      end
      chk("both_held", {31'h0, both_seen}, {31'h0, rows[i].sim});
      apb(1'b0, ADDR_IRQ_STAT, 32'h0);
      chk("irq_stat", rd_v, 32'h1);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk("empty", {31'h0, rd_v[ST_EMPTY_BIT]}, 32'h0);
    end
    $display("test modes done");
    // Enable, mask and clear of the level interrupt
    apb(1'b1, ADDR_IRQ_EN, 32'h1);
    repeat (3) @(posedge mclk);
    chk("irq_on", {31'h0, irq}, 32'h1);
    apb(1'b1, ADDR_IRQ_EN, 32'h0);
    repeat (3) @(posedge mclk);
    chk("irq_masked", {31'h0, irq}, 32'h0);
    apb(1'b1, ADDR_IRQ_EN, 32'h1);
    apb(1'b1, ADDR_IRQ_CLR, 32'h7);
    repeat (3) @(posedge mclk);
    chk("irq_cleared", {31'h0, irq}, 32'h0);
    $display("test irq done");
    // Each source alone, then source 2 fired with sources 0 and 2 enabled
    apb(1'b1, ADDR_CONV_CTRL, 32'he400);
    for (int i = 0; i < 6; i++) begin
      en = (i < 5) ? 5'(1 << i) : 5'h05;
      fire = (i < 5) ? en : 5'h04;
      apb(1'b1, ADDR_TRIG_CTRL, {27'h0, en});
      apb(1'b1, ADDR_IRQ_CLR, 32'h7);
      pulse(~en);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk("not_started", {31'h0, rd_v[ST_BUSY_BIT]}, 32'h0);
      pulse(fire);
      apb(1'b0, ADDR_CONV_CTRL, 32'h0);
      chk("go_set", {31'h0, rd_v[CC_GO_BIT]}, 32'h1);
      pulse(fire);
      wait_idle();
      apb(1'b0, ADDR_CONV_CTRL, 32'h0);
      chk("go_clear", {31'h0, rd_v[CC_GO_BIT]}, 32'h0);
      apb(1'b0, ADDR_IRQ_STAT, 32'h0);
      chk("events", rd_v, 32'h7);
    end
    apb(1'b1, ADDR_TRIG_CTRL, 32'h0);
    pulse(5'h1f);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("all_off", {31'h0, rd_v[ST_BUSY_BIT]}, 32'h0);
    $display("test triggers done");
    // Loop mode, four-group sequence, every depth code
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, ADDR_TRIG_CTRL, 32'(c << 6));
      apb(1'b1, ADDR_IRQ_CLR, 32'h7);
      base = done_cnt;
      apb(1'b1, ADDR_CONV_CTRL, 32'h17);
      for (int k = 1; k < 5; k++) begin
        for (int t = 0; t < 3000 && done_cnt < base + k; t++) @(posedge mclk);
        repeat (3) @(posedge mclk);
        apb(1'b0, ADDR_IRQ_STAT, 32'h0);
        chk("depth_flag", {31'h0, rd_v[EV_CONV_IRQ]}, 32'((c == 0) || (c == 1 && k > 1) || (c == 2 && k == 4)));
      end
      apb(1'b1, ADDR_CONV_CTRL, 32'h0);
      wait_idle();
    end
    $display("test depth done");
    // Acquisition length, with zero taken as two periods
    for (int a = 0; a < 5; a += 4) begin
      apb(1'b1, ADDR_CONV_CTRL, 32'(a << 16) | 32'h1);
      wait_idle();
      na = (a < 2) ? 2 : a;
      chk("acq_len", 32'((last_len > (na - 1) * TAD_CYC) && (last_len <= na * TAD_CYC + 2)), 32'h1);
    end
    $display("test acquisition done");
    wrap_up();
  end
endmodule // adc_trigger_sequencer_bench
`default_nettype wire
